// ### hdl/swl_pkg.sv
package swl_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // times in microseconds
  // ----------------------------------------
  localparam logic [8:0] RST_LOW_US = 9'(500);
  localparam logic [8:0] RST_DET_US = 9'(480);
  localparam logic [8:0] RST_REC_US = 9'(480);
  localparam logic [8:0] PRES_SAMPLE_US = 9'(70);
  localparam logic [7:0] PRES_WAIT_US = 8'(30);
  localparam logic [7:0] PRES_LOW_US = 8'(120);
  localparam logic [7:0] WR_SAMPLE_US = 8'(30);
  localparam logic [7:0] TX_HOLD_US = 8'(30);
  localparam logic [7:0] SLOT_END_US = 8'(60);
  localparam logic [8:0] SLOT_US = 9'(70);
  localparam logic [8:0] W1_LOW_US = 9'(6);
  localparam logic [8:0] W0_LOW_US = 9'(65);
  localparam logic [8:0] SLOT_OPEN_LOW_US = 9'(2);
  localparam logic [8:0] RD_SAMPLE_US = 9'(12);
  localparam logic [8:0] REC_US = 9'(3);

  // ----------------------------------------
  // bit counts
  // ----------------------------------------
  localparam logic [6:0] RX_LAST = 7'(7);
  localparam logic [6:0] ID_LAST = 7'(63);
  localparam logic [6:0] ID_BITS = 7'(64);
  localparam logic [6:0] SCR_LAST = 7'(71);
  localparam logic [2:0] BIT_LAST = 3'(7);

  // ----------------------------------------
  // commands, check value, master ops
  // ----------------------------------------
  localparam logic [7:0] CMD_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SKIP = 8'hcc;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_READ_SCR = 8'hbe;
  localparam logic [7:0] CMD_READ_PWR = 8'hb4;
  localparam logic [7:0] CRC_POLY = 8'h8c;
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;

  typedef enum logic [3:0] {
    S_WAIT = 4'h0, S_RSTLOW = 4'h1, S_PWAIT = 4'h2, S_PRES = 4'h3,
    S_ROM = 4'h4, S_MATCH = 4'h5, S_IDTX = 4'h6, S_FUNC = 4'h7,
    S_SCR = 4'h8, S_PWR = 4'h9, S_CONV = 4'ha
  } swl_sst_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_RST = 3'h1, M_LISTEN = 3'h2, M_SLOT = 3'h3, M_REC = 3'h4
  } swl_mst_t;

endpackage

// ### hdl/swl_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface swl_bus_if;
  logic mDqOut;
  logic mDqOe;
  logic sDqOut;
  logic sDqOe;
  logic dq;

  // open drain wire with pullup
  assign dq = ~((mDqOe & ~mDqOut) | (sDqOe & ~sDqOut));

  modport master (input dq, output mDqOut, output mDqOe);
  modport slave (input dq, output sDqOut, output sDqOe);
endinterface
`default_nettype wire

// ### hdl/swl_slave.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - scratchpad goes out LSB first, nine bytes
// - long low aborts readout, restarts initialization
// - check byte built on the fly, sent last
// - supply query: parasite pulls low, else released
// - master starts slots; device only sends presence
// - master holds reset low 480 us minimum
// - presence starts 15 to 60 us after rise
// - presence low 60 to 240 us
// - one bit per time slot
// - write slot 60 us, 1 us recovery
// - write one released within 15 us
// - write zero held low whole slot; master releases at 65 us of its 70 us slot
// - device samples 15 to 60 us in
// - master issues read slots after read commands
// - read slot 60 us, opened by short low
// - zero pulled low, released before slot end
// - device data valid first 15 us
// - master samples late, short low drive
// - master may poll conversion with read slots
// - order: init, addressing, function; else ignore
// - addressing codes are 8-bit, 64-bit identity
// - match: only equal identity answers
// - external supply: 0 converting, 1 done
module swl_slave
  import swl_pkg::*;
#(
  parameter int TICK_CYC = US_CYC,
  // identity value is arbitrary
  parameter logic [63:0] DEV_ID = 64'h0123_4567_89ab_cdef
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  swl_bus_if.slave bus,
  input wire logic [63:0] scratch,
  input wire logic parasite,
  input wire logic convDone,
  output logic convStart
);

  if (TICK_CYC < 2 || TICK_CYC > 128)
  begin : g_chk
    $error("swl_slave: TICK_CYC out of range");
  end

  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  typedef struct packed {
    swl_sst_t st;
    logic sync0;
    logic sync1;
    logic prev;
    logic [6:0] div;
    logic [8:0] lowUs;
    logic [7:0] slotUs;
    logic slotAct;
    logic [6:0] bitCnt;
    logic [7:0] sh;
    logic [7:0] crc;
    logic drive;
    logic convPulse;
  } swl_sreg_t;

  swl_sreg_t r_reg;
  swl_sreg_t r_next;
  logic tick;
  logic fall;
  logic rise;
  logic sample;
  logic rxBit;
  logic [7:0] rxByte;
  logic txNow;
  logic txBit;
  logic fb;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.convPulse = 1'b0;
    r_next.sync0 = bus.dq;
    r_next.sync1 = r_reg.sync0;
    r_next.prev = r_reg.sync1;
    tick = (r_reg.div == TICK_LAST);
    r_next.div = tick ? 7'h00 : r_reg.div + 7'h01;
    fall = r_reg.prev & ~r_reg.sync1;
    rise = ~r_reg.prev & r_reg.sync1;
    rxBit = r_reg.sync1;
    rxByte = {rxBit, r_reg.sh[7:1]};
    txNow = 1'b0;
    txBit = 1'b1;
    fb = 1'b0;
    if (r_reg.sync1)
      r_next.lowUs = 9'h000;
    else if (tick && r_reg.lowUs != RST_DET_US)
      r_next.lowUs = r_reg.lowUs + 9'h001;
    if (fall)
    begin
      r_next.slotAct = 1'b1;
      r_next.slotUs = 8'h00;
    end
    else if (tick && r_reg.slotAct)
    begin
      r_next.slotUs = r_reg.slotUs + 8'h01;
      if (r_reg.slotUs == SLOT_END_US)
        r_next.slotAct = 1'b0;
    end
    sample = tick && r_reg.slotAct && r_reg.slotUs == WR_SAMPLE_US;
    if (tick && r_reg.slotUs == TX_HOLD_US)
      r_next.drive = 1'b0;
    case (r_reg.st)
      S_WAIT:
        r_next.bitCnt = 7'h00;
      S_RSTLOW:
        if (rise)
        begin
          r_next.st = S_PWAIT;
          r_next.slotUs = 8'h00;
          r_next.slotAct = 1'b0;
        end
      S_PWAIT:
      begin
        r_next.slotAct = 1'b0;
        r_next.slotUs = tick ? r_reg.slotUs + 8'h01 : r_reg.slotUs;
        if (tick && r_reg.slotUs == PRES_WAIT_US)
        begin
          r_next.st = S_PRES;
          r_next.slotUs = 8'h00;
          r_next.drive = 1'b1;
        end
      end
      S_PRES:
      begin
        r_next.slotAct = 1'b0;
        r_next.slotUs = tick ? r_reg.slotUs + 8'h01 : r_reg.slotUs;
        r_next.drive = 1'b1;
        if (tick && r_reg.slotUs == PRES_LOW_US)
        begin
          r_next.drive = 1'b0;
          r_next.st = S_ROM;
          r_next.bitCnt = 7'h00;
        end
      end
      S_ROM:
        if (sample)
        begin
          r_next.sh = rxByte;
          r_next.bitCnt = r_reg.bitCnt + 7'h01;
          if (r_reg.bitCnt == RX_LAST)
          begin
            r_next.bitCnt = 7'h00;
            case (rxByte)
              CMD_SKIP: r_next.st = S_FUNC;
              CMD_MATCH: r_next.st = S_MATCH;
              CMD_READ_ID: r_next.st = S_IDTX;
              CMD_SEARCH: r_next.st = S_WAIT;
              default: r_next.st = S_WAIT;
            endcase
          end
        end
      S_MATCH:
        if (sample)
        begin
          r_next.bitCnt = r_reg.bitCnt + 7'h01;
          if (rxBit != DEV_ID[r_reg.bitCnt[5:0]])
            r_next.st = S_WAIT;
          else if (r_reg.bitCnt == ID_LAST)
          begin
            r_next.st = S_FUNC;
            r_next.bitCnt = 7'h00;
          end
        end
      S_IDTX:
      begin
        if (fall)
        begin
          txNow = 1'b1;
          txBit = DEV_ID[r_reg.bitCnt[5:0]];
          r_next.bitCnt = r_reg.bitCnt + 7'h01;
        end
        if (tick && r_reg.slotUs == TX_HOLD_US && r_reg.bitCnt == ID_BITS)
        begin
          r_next.st = S_FUNC;
          r_next.bitCnt = 7'h00;
        end
      end
      S_FUNC:
        if (sample)
        begin
          r_next.sh = rxByte;
          r_next.bitCnt = r_reg.bitCnt + 7'h01;
          if (r_reg.bitCnt == RX_LAST)
          begin
            r_next.bitCnt = 7'h00;
            r_next.crc = 8'h00;
            case (rxByte)
              CMD_READ_SCR: r_next.st = S_SCR;
              CMD_READ_PWR: r_next.st = S_PWR;
              CMD_CONVERT:
              begin
                r_next.st = S_CONV;
                r_next.convPulse = 1'b1;
              end
              default: r_next.st = S_WAIT;
            endcase
          end
        end
      S_SCR:
        if (fall)
        begin
          txNow = 1'b1;
          r_next.bitCnt = r_reg.bitCnt + 7'h01;
          if (!r_reg.bitCnt[6])
          begin
            txBit = scratch[r_reg.bitCnt[5:0]];
            fb = txBit ^ r_reg.crc[0];
            r_next.crc = {1'b0, r_reg.crc[7:1]} ^ (fb ? CRC_POLY : 8'h00);
          end
          else
          begin
            txBit = r_reg.crc[0];
            r_next.crc = {1'b0, r_reg.crc[7:1]};
          end
          if (r_reg.bitCnt == SCR_LAST)
            r_next.st = S_WAIT;
        end
      S_PWR:
        if (fall)
        begin
          txNow = 1'b1;
          txBit = ~parasite;
        end
      S_CONV:
        if (fall)
        begin
          txNow = 1'b1;
          txBit = parasite | convDone;
        end
      default:
        r_next.st = S_WAIT;
    endcase
    if (txNow)
      r_next.drive = ~txBit;
    if (r_reg.lowUs == RST_DET_US && r_reg.st != S_RSTLOW)
    begin
      r_next.st = S_RSTLOW;
      r_next.drive = 1'b0;
    end
  end

  // ----------------------------------------
  // state register and outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign bus.sDqOe = r_reg.drive;
  assign bus.sDqOut = 1'b0;
  assign convStart = r_reg.convPulse;

endmodule
`default_nettype wire

// ### hdl/swl_master.sv
`timescale 1ns/100ps
`default_nettype none
module swl_fifo
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  if (W < 1 || D < 2 || (D & (D - 1)) != 0)
  begin : g_chk
    $error("swl_fifo: bad width or depth");
  end

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } swl_fifo_t;

  swl_fifo_t r_reg;
  swl_fifo_t r_next;

  assign inReady = ~((r_reg.wp[AW] != r_reg.rp[AW]) &&
    (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]));
  assign outValid = (r_reg.wp != r_reg.rp);
  assign outData = r_reg.mem[r_reg.rp[AW-1:0]];

  always_comb
  begin
    r_next = r_reg;
    if (inValid && inReady)
    begin
      r_next.mem[r_reg.wp[AW-1:0]] = inData;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (outValid && outReady)
      r_next.rp = r_reg.rp + 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

endmodule

module swl_master
  import swl_pkg::*;
#(
  parameter int TICK_CYC = US_CYC,
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  swl_bus_if.master bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [1:0] cmdOp,
  input wire logic [7:0] cmdData,
  output logic presence,
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData
);

  if (TICK_CYC < 2 || TICK_CYC > 128)
  begin : g_chk
    $error("swl_master: TICK_CYC out of range");
  end

  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  typedef struct packed {
    swl_mst_t st;
    logic sync0;
    logic sync1;
    logic [6:0] div;
    logic [8:0] tUs;
    logic [1:0] op;
    logic [7:0] sh;
    logic [2:0] bitCnt;
    logic drive;
    logic presence;
    logic push;
  } swl_mreg_t;

  swl_mreg_t r_reg;
  swl_mreg_t r_next;
  logic tick;
  logic isRead;
  logic fifoInReady;
  logic [8:0] lowEnd;

  // ----------------------------------------
  // slot sequencer
  // ----------------------------------------
  assign cmdReady = (r_reg.st == M_IDLE) && (cmdOp != OP_READ || fifoInReady);

  always_comb
  begin
    r_next = r_reg;
    r_next.push = 1'b0;
    r_next.sync0 = bus.dq;
    r_next.sync1 = r_reg.sync0;
    tick = (r_reg.div == TICK_LAST);
    r_next.div = tick ? 7'h00 : r_reg.div + 7'h01;
    r_next.tUs = tick ? r_reg.tUs + 9'h001 : r_reg.tUs;
    isRead = (r_reg.op == OP_READ);
    lowEnd = isRead ? SLOT_OPEN_LOW_US :
      (r_reg.sh[0] ? W1_LOW_US : W0_LOW_US);
    case (r_reg.st)
      M_IDLE:
        if (cmdValid && cmdReady)
        begin
          r_next.op = cmdOp;
          r_next.sh = cmdData;
          r_next.bitCnt = 3'h0;
          r_next.tUs = 9'h000;
          r_next.drive = 1'b1;
          r_next.st = (cmdOp == OP_RESET) ? M_RST : M_SLOT;
          if (cmdOp == OP_RESET)
            r_next.presence = 1'b0;
        end
      M_RST:
        if (tick && r_reg.tUs == RST_LOW_US)
        begin
          r_next.drive = 1'b0;
          r_next.tUs = 9'h000;
          r_next.st = M_LISTEN;
        end
      M_LISTEN:
      begin
        if (tick && r_reg.tUs == PRES_SAMPLE_US)
          r_next.presence = ~r_reg.sync1;
        if (tick && r_reg.tUs == RST_REC_US)
          r_next.st = M_IDLE;
      end
      M_SLOT:
      begin
        if (tick && r_reg.tUs == lowEnd)
          r_next.drive = 1'b0;
        if (tick && isRead && r_reg.tUs == RD_SAMPLE_US)
          r_next.sh = {r_reg.sync1, r_reg.sh[7:1]};
        if (tick && r_reg.tUs == SLOT_US)
        begin
          r_next.drive = 1'b0;
          r_next.tUs = 9'h000;
          r_next.st = M_REC;
          if (!isRead)
            r_next.sh = {1'b0, r_reg.sh[7:1]};
        end
      end
      M_REC:
        if (tick && r_reg.tUs == REC_US)
        begin
          r_next.bitCnt = r_reg.bitCnt + 3'h1;
          if (r_reg.bitCnt == BIT_LAST)
          begin
            r_next.st = M_IDLE;
            r_next.push = isRead;
          end
          else
          begin
            r_next.st = M_SLOT;
            r_next.tUs = 9'h000;
            r_next.drive = 1'b1;
          end
        end
      default:
        r_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign bus.mDqOe = r_reg.drive;
  assign bus.mDqOut = 1'b0;
  assign presence = r_reg.presence;

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  swl_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(r_reg.push),
    .inReady(fifoInReady),
    .inData(r_reg.sh),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

endmodule
`default_nettype wire

// ### bench/swl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module swl_checker
#(
  parameter int TICK_CYC = 100
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic mDqOut,
  input wire logic mDqOe,
  input wire logic sDqOut,
  input wire logic sDqOe,
  input wire logic dq
);
  localparam int T = TICK_CYC;
  logic [15:0] lowCnt_reg;
  logic [15:0] fallCnt_reg;
  logic [15:0] relCnt_reg;
  logic [15:0] sLowCnt_reg;
  logic mPrev_reg;
  logic rstSeen_reg;

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowCnt_reg <= 16'h0;
      fallCnt_reg <= 16'h0;
      relCnt_reg <= 16'h0;
      sLowCnt_reg <= 16'h0;
      mPrev_reg <= 1'b0;
      rstSeen_reg <= 1'b0;
    end
    else
    begin
      mPrev_reg <= mDqOe;
      lowCnt_reg <= mDqOe ? lowCnt_reg + 16'h1 : 16'h0;
      sLowCnt_reg <= sDqOe ? sLowCnt_reg + 16'h1 : 16'h0;
      if (mDqOe && !mPrev_reg)
        fallCnt_reg <= 16'h0;
      else if (fallCnt_reg != 16'hffff)
        fallCnt_reg <= fallCnt_reg + 16'h1;
      if (!mDqOe && mPrev_reg)
        relCnt_reg <= 16'h0;
      else if (relCnt_reg != 16'hffff)
        relCnt_reg <= relCnt_reg + 16'h1;
      if (!mDqOe && mPrev_reg && lowCnt_reg >= 16'(480 * T))
        rstSeen_reg <= 1'b1;
      else if (!sDqOe && sLowCnt_reg != 16'h0)
        rstSeen_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  open_drain_a: assert property ((sDqOe || mDqOe) |-> !(sDqOut || mDqOut))
    else $error("line driven high");
  slave_start_a: assert property ($rose(sDqOe) |-> rstSeen_reg || fallCnt_reg <= 16'(15 * T))
    else $error("slave drive without master slot");
  pres_delay_a: assert property ($rose(sDqOe) && rstSeen_reg |->
    relCnt_reg >= 16'(15 * T) && relCnt_reg <= 16'(60 * T))
    else $error("presence start out of window");
  pres_early_a: assert property (rstSeen_reg && relCnt_reg < 16'(15 * T) |-> !sDqOe)
    else $error("presence too early");
  pres_len_a: assert property ($fell(sDqOe) && rstSeen_reg |->
    sLowCnt_reg >= 16'(60 * T) && sLowCnt_reg <= 16'(240 * T))
    else $error("presence length wrong");
  zero_hold_a: assert property ($fell(sDqOe) && !rstSeen_reg |-> fallCnt_reg >= 16'(15 * T))
    else $error("read zero released early");
  zero_release_a: assert property (sDqOe && !rstSeen_reg |-> sLowCnt_reg <= 16'(60 * T))
    else $error("read zero not released");
  reset_abort_a: assert property (lowCnt_reg == 16'(100 * T) |-> !sDqOe)
    else $error("slave drives during bus reset");

  cover property ($fell(sDqOe) && rstSeen_reg);
  cover property ($fell(sDqOe) && !rstSeen_reg);
  cover property (lowCnt_reg == 16'(480 * T));
  cover property (!dq && sDqOe && !mDqOe);
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import swl_pkg::*;
  localparam int TK = 2;
  // identity value is arbitrary
  localparam logic [63:0] TB_ID = 64'h5a3c_96e1_0f87_d24b;
  localparam logic [63:0] SCR = 64'hc3_10_7e_a5_00_ff_42_19;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdReady;
  logic [1:0] cmdOp = OP_WRITE;
  logic [7:0] cmdData = 8'h00;
  logic presence;
  logic rxValid;
  logic rxReady = 1'b0;
  logic [7:0] rxData;
  logic parasite = 1'b0;
  logic convDone = 1'b0;
  logic convStart;
  int fails = 0;
  int n_tests = 0;
  int convCnt = 0;

  swl_bus_if i_swl_bus_if ();
  swl_master #(.TICK_CYC(TK), .FIFO_DEPTH(8)) i_swl_master (.core_clk(core_clk),
    .arst_n(arst_n), .bus(i_swl_bus_if.master), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdData(cmdData), .presence(presence), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData));
  swl_slave #(.TICK_CYC(TK), .DEV_ID(TB_ID)) i_swl_slave (.core_clk(core_clk),
    .arst_n(arst_n), .bus(i_swl_bus_if.slave), .scratch(SCR), .parasite(parasite),
    .convDone(convDone), .convStart(convStart));
  swl_checker #(.TICK_CYC(TK)) i_swl_checker (.core_clk(core_clk), .arst_n(arst_n),
    .mDqOut(i_swl_bus_if.mDqOut), .mDqOe(i_swl_bus_if.mDqOe),
    .sDqOut(i_swl_bus_if.sDqOut), .sDqOe(i_swl_bus_if.sDqOe), .dq(i_swl_bus_if.dq));

  always #5 core_clk = ~core_clk;
  always @(negedge core_clk)
    if (convStart === 1'b1)
      convCnt++;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic hang(input string nm);
    $display("FAIL %s expected done seen timeout", nm);
    fails++;
    give_verdict();
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 5000; i++)
    begin
      @(negedge core_clk);
      if (cmdReady === 1'b1)
        return;
    end
    hang("cmdReady");
  endtask

  task automatic do_cmd(input logic [1:0] op, input logic [7:0] d);
    cmdOp <= op;
    cmdData <= d;
    cmdValid <= 1'b1;
    wait_ready();
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdOp <= OP_WRITE;
    @(posedge core_clk);
    wait_ready();
    @(posedge core_clk);
  endtask

  task automatic pop(input string nm, input logic [7:0] e);
    int i;
    for (i = 0; i < 5000; i++)
    begin
      @(negedge core_clk);
      if (rxValid === 1'b1)
        break;
    end
    if (rxValid !== 1'b1)
      hang(nm);
    chk(nm, 64'(e), 64'(rxData));
    @(posedge core_clk);
    rxReady <= 1'b1;
    @(posedge core_clk);
    rxReady <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] e);
    do_cmd(OP_READ, 8'h00);
    pop(nm, e);
  endtask

  task automatic init();
    do_cmd(OP_RESET, 8'h00);
    chk("presence", 64'h1, 64'(presence));
  endtask

  function automatic logic [7:0] crc_of(input logic [63:0] v);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int k = 0; k < 64; k++)
    begin
      fb = c[0] ^ v[k];
      c = c >> 1;
      if (fb)
        c = c ^ 8'h8c;
    end
    return c;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_order();
    do_cmd(OP_WRITE, CMD_READ_SCR);
    rd("unaddressed read", 8'hff);
  endtask

  task automatic t_scratch();
    init();
    do_cmd(OP_WRITE, CMD_SKIP);
    do_cmd(OP_WRITE, CMD_READ_SCR);
    for (int k = 0; k < 8; k++)
      do_cmd(OP_READ, 8'h00);
    cmdOp <= OP_READ;
    cmdValid <= 1'b1;
    repeat (20) @(negedge core_clk);
    chk("cmdReady full", 64'h0, 64'(cmdReady));
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdOp <= OP_WRITE;
    @(posedge core_clk);
    for (int k = 0; k < 8; k++)
      pop("scratch byte", SCR[8*k +: 8]);
    rd("check byte", crc_of(SCR));
  endtask

  task automatic t_abort();
    init();
    do_cmd(OP_WRITE, CMD_SKIP);
    do_cmd(OP_WRITE, CMD_READ_SCR);
    rd("first byte", SCR[7:0]);
    init();
    do_cmd(OP_WRITE, CMD_SKIP);
    do_cmd(OP_WRITE, CMD_READ_PWR);
    parasite <= 1'b1;
    rd("parasite supply", 8'h00);
    parasite <= 1'b0;
    rd("external supply", 8'hff);
  endtask

  task automatic t_match();
    int base;
    base = convCnt;
    init();
    do_cmd(OP_WRITE, CMD_MATCH);
    for (int k = 0; k < 8; k++)
      do_cmd(OP_WRITE, ~TB_ID[8*k +: 8]);
    do_cmd(OP_WRITE, CMD_CONVERT);
    chk("start ignored", 64'h0, 64'(convCnt - base));
    init();
    do_cmd(OP_WRITE, CMD_MATCH);
    for (int k = 0; k < 8; k++)
      do_cmd(OP_WRITE, TB_ID[8*k +: 8]);
    do_cmd(OP_WRITE, CMD_CONVERT);
    chk("start pulses", 64'h1, 64'(convCnt - base));
    rd("converting", 8'h00);
    convDone <= 1'b1;
    rd("converted", 8'hff);
  endtask

  task automatic t_readid();
    init();
    do_cmd(OP_WRITE, CMD_READ_ID);
    for (int k = 0; k < 8; k++)
      rd("identity byte", TB_ID[8*k +: 8]);
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_order();
    t_scratch();
    t_abort();
    t_match();
    t_readid();
    give_verdict();
  end
endmodule
`default_nettype wire
